/* verilog/gxp_pkg.sv */
// Constants, state type and field layout of the port expander core
package gxp_pkg;

    // ****************************************************************
    // Widths and address
    // ****************************************************************
    localparam int         PORT_W    = 8;
    localparam int         SEL_MSB   = 1;
    localparam int         RW_BIT    = 0;
    localparam logic [5:0] ADDR_HI   = 6'h10;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_STEP  = 4'h1;

    // ****************************************************************
    // Register selects and reset values
    // ****************************************************************
    localparam logic [1:0] REG_IN    = 2'h0;
    localparam logic [1:0] REG_OUT   = 2'h1;
    localparam logic [1:0] REG_INV   = 2'h2;
    localparam logic [1:0] REG_DIR   = 2'h3;
    localparam logic [7:0] OUT_RST   = 8'hff;
    localparam logic [7:0] INV_RST   = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'hff;
    localparam logic [7:0] PTR_RST   = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************************************************************
    // Bus state machine
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_A,
        ST_RX,
        ST_ACK_R,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } gxp_state_e;

endpackage

/* verilog/gxp_sync.sv */
// Two flip-flop synchroniser for a group of outside levels
`timescale 1ns/1ps
module gxp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Levels
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    // ****************************************************************
    // Per-bit chain; the first stage feeds only the second
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    meta_q <= RST_VAL[g];
                    sync_q <= RST_VAL[g];
                end else begin
                    meta_q <= i_d[g];
                    sync_q <= meta_q;
                end
            end
            assign o_q[g] = sync_q;
        end
    endgenerate

endmodule

/* verilog/gxp_link_cond.sv */
// Edge and start/stop detection on the synchronised serial lines
`timescale 1ns/1ps
module gxp_link_cond (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Synchronised lines
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Events, one cycle each
    output logic      o_scl_rise,
    output logic      o_scl_fall,
    output logic      o_start,
    output logic      o_stop
);

    logic scl_q;
    logic sda_q;

    // Idle bus is high on both lines
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    assign o_scl_rise = i_scl & ~scl_q;
    assign o_scl_fall = ~i_scl & scl_q;
    // Data moving while the clock stays high marks a frame boundary
    assign o_start = i_scl & scl_q & sda_q & ~i_sda;
    assign o_stop  = i_scl & scl_q & ~sda_q & i_sda;

endmodule

/* verilog/gxp_core.sv */
// Register and serial bus core of the 8-bit port expander
`timescale 1ns/1ps
module gxp_core (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_reset_pin_n,
    // Address select strap
    input  wire logic       i_addr_sel,
    // Serial link
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Port pins
    input  wire logic [7:0] i_port,
    output logic      [7:0] o_port_out,
    output logic      [7:0] o_port_oe,
    // Interrupt, open drain
    output logic            o_irq_n_out,
    output logic            o_irq_n_oe
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0]             bus_s;
    logic [7:0]             pin_s;
    logic                   rst_pin_n_s;
    logic                   addr_sel_s;
    logic                   scl_s;
    logic                   sda_s;
    logic                   rst;

    gxp_sync #(
        .WIDTH   (4),
        .RST_VAL (4'hf)
    ) u_sync_bus (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     ({i_reset_pin_n, i_addr_sel, i_scl, i_sda}),
        .o_q     (bus_s)
    );

    gxp_sync #(
        .WIDTH   (gxp_pkg::PORT_W),
        .RST_VAL (gxp_pkg::BYTE_ZERO)
    ) u_sync_pin (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     (i_port),
        .o_q     (pin_s)
    );

    assign rst_pin_n_s = bus_s[3];
    assign addr_sel_s  = bus_s[2];
    assign scl_s       = bus_s[1];
    assign sda_s       = bus_s[0];
    // Either reset source puts the core registers back to defaults; the synchronisers reset on i_reset only
    assign rst = i_reset | ~rst_pin_n_s;

    // ****************************************************************
    // Link events
    // ****************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    gxp_link_cond u_cond (
        .i_clk      (i_clk),
        .i_reset    (rst),
        .i_scl      (scl_s),
        .i_sda      (sda_s),
        .o_scl_rise (scl_rise),
        .o_scl_fall (scl_fall),
        .o_start    (start),
        .o_stop     (stop)
    );

    // ****************************************************************
    // State and datapath registers
    // ****************************************************************
    gxp_pkg::gxp_state_e state_q;
    logic [3:0]          cnt_q;
    logic [7:0]          shift_q;
    logic [7:0]          tx_q;
    logic                rw_q;
    logic                first_q;
    logic                mack_q;
    logic                addressed_q;
    logic                sda_oe_q;
    logic [7:0]          ptr_q;
    logic [7:0]          out_latch_q;
    logic [7:0]          invert_q;
    logic [7:0]          dir_q;
    logic [7:0]          drive_q;
    logic [7:0]          ref_q;
    logic                irq_q;
    logic                pull_q;

    logic                byte_done;
    logic                addr_hit;
    logic [1:0]          sel;
    logic [7:0]          in_level;
    logic [7:0]          rd_data;
    logic                wr_stb;
    logic                ptr_stb;
    logic                rd_clear;
    logic                clear_ev;
    logic                pend;

    assign byte_done = scl_fall && (cnt_q == gxp_pkg::BYTE_BITS);
    assign addr_hit  = (shift_q[7:1] == {gxp_pkg::ADDR_HI, addr_sel_s});
    assign sel       = ptr_q[gxp_pkg::SEL_MSB:0];
    // Inversion only touches pins that are inputs
    assign in_level  = pin_s ^ (invert_q & dir_q);

    // ****************************************************************
    // Read data select
    // ****************************************************************
    always_comb begin
        case (sel)
            gxp_pkg::REG_IN:  rd_data = in_level;
            gxp_pkg::REG_OUT: rd_data = out_latch_q;
            gxp_pkg::REG_INV: rd_data = invert_q;
            default:          rd_data = dir_q;
        endcase
    end

    // ****************************************************************
    // Bus state machine
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (rst) begin
            state_q <= gxp_pkg::ST_IDLE;
        end else if (start) begin
            state_q <= gxp_pkg::ST_ADDR;
        end else if (stop) begin
            state_q <= gxp_pkg::ST_IDLE;
        end else begin
            case (state_q)
                gxp_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        state_q <= addr_hit ? gxp_pkg::ST_ACK_A
                                            : gxp_pkg::ST_IGNORE;
                    end
                end
                gxp_pkg::ST_ACK_A: begin
                    if (scl_fall) begin
                        state_q <= rw_q ? gxp_pkg::ST_TX : gxp_pkg::ST_RX;
                    end
                end
                gxp_pkg::ST_RX: begin
                    if (byte_done) begin
                        state_q <= gxp_pkg::ST_ACK_R;
                    end
                end
                gxp_pkg::ST_ACK_R: begin
                    // No byte count limit on writes
                    if (scl_fall) begin
                        state_q <= gxp_pkg::ST_RX;
                    end
                end
                gxp_pkg::ST_TX: begin
                    if (byte_done) begin
                        state_q <= gxp_pkg::ST_MACK;
                    end
                end
                gxp_pkg::ST_MACK: begin
                    if (scl_fall) begin
                        state_q <= mack_q ? gxp_pkg::ST_TX
                                          : gxp_pkg::ST_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Bit counter and receive shifter
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (rst || start) begin
            cnt_q <= gxp_pkg::CNT_ZERO;
        end else if (scl_rise && (state_q == gxp_pkg::ST_ADDR
                     || state_q == gxp_pkg::ST_RX
                     || state_q == gxp_pkg::ST_TX)) begin
            cnt_q <= cnt_q + gxp_pkg::CNT_STEP;
        end else if (scl_fall && (state_q == gxp_pkg::ST_ACK_A
                     || state_q == gxp_pkg::ST_ACK_R
                     || state_q == gxp_pkg::ST_MACK)) begin
            cnt_q <= gxp_pkg::CNT_ZERO;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            shift_q <= gxp_pkg::BYTE_ZERO;
        end else if (scl_rise && (state_q == gxp_pkg::ST_ADDR
                     || state_q == gxp_pkg::ST_RX)) begin
            shift_q <= {shift_q[6:0], sda_s};
        end
    end

    // ****************************************************************
    // Transaction flags
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (rst) begin
            rw_q        <= 1'b0;
            first_q     <= 1'b0;
            mack_q      <= 1'b0;
            addressed_q <= 1'b0;
        end else begin
            if (state_q == gxp_pkg::ST_ADDR && byte_done && addr_hit) begin
                rw_q        <= shift_q[gxp_pkg::RW_BIT];
                addressed_q <= 1'b1;
            end else if (stop) begin
                addressed_q <= 1'b0;
            end
            if (state_q == gxp_pkg::ST_ACK_A && scl_fall) begin
                first_q <= ~rw_q;
            end else if (state_q == gxp_pkg::ST_ACK_R && scl_rise) begin
                first_q <= 1'b0;
            end
            if (state_q == gxp_pkg::ST_MACK && scl_rise) begin
                mack_q <= ~sda_s;
            end
        end
    end

    // ****************************************************************
    // Data line drive (open drain, enable means pull low)
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (rst || start || stop) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            case (state_q)
                gxp_pkg::ST_ADDR: begin
                    if (byte_done && addr_hit) begin
                        sda_oe_q <= 1'b1;
                    end
                end
                gxp_pkg::ST_ACK_A: begin
                    sda_oe_q <= rw_q & ~rd_data[7];
                end
                gxp_pkg::ST_RX: begin
                    if (byte_done) begin
                        sda_oe_q <= 1'b1;
                    end
                end
                gxp_pkg::ST_TX: begin
                    sda_oe_q <= byte_done ? 1'b0 : ~tx_q[6];
                end
                gxp_pkg::ST_MACK: begin
                    sda_oe_q <= mack_q & ~rd_data[7];
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Transmit byte is captured when its first bit goes out
    always_ff @(posedge i_clk) begin
        if (rst) begin
            tx_q <= gxp_pkg::BYTE_ZERO;
        end else if (scl_fall && ((state_q == gxp_pkg::ST_ACK_A && rw_q)
                     || (state_q == gxp_pkg::ST_MACK && mack_q))) begin
            tx_q <= rd_data;
        end else if (scl_fall && state_q == gxp_pkg::ST_TX) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // ****************************************************************
    // Registers written from the link
    // ****************************************************************
    assign ptr_stb = state_q == gxp_pkg::ST_ACK_R && scl_rise && first_q;
    assign wr_stb  = state_q == gxp_pkg::ST_ACK_R && scl_rise && !first_q;

    // Pointer survives across transactions so repeated reads need no command
    always_ff @(posedge i_clk) begin
        if (rst) begin
            ptr_q <= gxp_pkg::PTR_RST;
        end else if (ptr_stb) begin
            ptr_q <= shift_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            out_latch_q <= gxp_pkg::OUT_RST;
        end else if (wr_stb && sel == gxp_pkg::REG_OUT) begin
            out_latch_q <= shift_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            invert_q <= gxp_pkg::INV_RST;
        end else if (wr_stb && sel == gxp_pkg::REG_INV) begin
            invert_q <= shift_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            dir_q <= gxp_pkg::DIR_RST;
        end else if (wr_stb && sel == gxp_pkg::REG_DIR) begin
            dir_q <= shift_q;
        end
    end

    // Pin drivers follow the direction one cycle later
    always_ff @(posedge i_clk) begin
        if (rst) begin
            drive_q <= ~gxp_pkg::DIR_RST;
        end else begin
            drive_q <= ~dir_q;
        end
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    // A changed input pin differs from the level seen at the last clear,
    // so a pin returning to that level clears it by itself.
    assign rd_clear = state_q == gxp_pkg::ST_MACK && scl_rise
                      && sel == gxp_pkg::REG_IN;
    assign clear_ev = rd_clear || (stop && addressed_q);
    assign pend     = |((pin_s ^ ref_q) & dir_q);

    // Change landing in the clear cycle itself may be missed
    always_ff @(posedge i_clk) begin
        if (rst || clear_ev) begin
            ref_q <= pin_s;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= pend;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            pull_q <= 1'b0;
        end else begin
            pull_q <= 1'b0;
        end
    end

    assign o_sda_out   = pull_q;
    assign o_sda_oe    = sda_oe_q;
    assign o_port_out  = out_latch_q;
    assign o_port_oe   = drive_q;
    assign o_irq_n_out = pull_q;
    assign o_irq_n_oe  = irq_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (rst);

    a_addr_ack: assert property (
        state_q == gxp_pkg::ST_ADDR && byte_done && addr_hit && !start
        && !stop |=> sda_oe_q && state_q == gxp_pkg::ST_ACK_A)
        else $error("matching address not acknowledged");

    a_addr_miss: assert property (
        state_q == gxp_pkg::ST_ADDR && byte_done && !addr_hit && !start
        && !stop |=> !sda_oe_q && state_q == gxp_pkg::ST_IGNORE)
        else $error("foreign address acknowledged");

    a_nack_release: assert property (
        state_q == gxp_pkg::ST_MACK && scl_fall && !mack_q && !start
        |=> !sda_oe_q && $stable(sda_oe_q) [*2])
        else $error("data line held after master nack");

    a_ptr_load: assert property (
        ptr_stb && !start && !stop |=> ptr_q == $past(shift_q))
        else $error("command byte not stored in pointer");

    a_in_ro: assert property (
        wr_stb && sel == gxp_pkg::REG_IN |=> $stable(out_latch_q)
        && $stable(invert_q) && $stable(dir_q))
        else $error("write to input register changed state");

    a_port_drive: assert property (
        ##1 o_port_oe == ~$past(dir_q) && o_port_out == out_latch_q)
        else $error("pin drive not tied to direction");

    a_inv_level: assert property (
        sel == gxp_pkg::REG_IN |-> rd_data == (pin_s ^ (invert_q & dir_q)))
        else $error("input register polarity wrong");

    a_irq_raise: assert property (
        $changed(pin_s) && |(($past(pin_s) ^ pin_s) & dir_q) && !clear_ev
        && $stable(dir_q)
        && ((pin_s ^ ref_q) & dir_q) != gxp_pkg::BYTE_ZERO |=> o_irq_n_oe)
        else $error("input edge did not raise interrupt");

    a_irq_outpin: assert property (
        dir_q == gxp_pkg::BYTE_ZERO |=> !o_irq_n_oe)
        else $error("output pins raised interrupt");

    a_read_clear: assert property (
        rd_clear && !start |=> ref_q == $past(pin_s))
        else $error("input read did not clear interrupt");

    a_stop_clear: assert property (
        stop && addressed_q ##1 $stable(pin_s) [*2] |-> !o_irq_n_oe)
        else $error("stop did not release interrupt");

    a_wr_load: assert property (
        wr_stb && sel == gxp_pkg::REG_OUT && !start && !stop
        |=> out_latch_q == $past(shift_q))
        else $error("write data not loaded at ack rise");

    a_reset_def: assert property (
        @(posedge i_clk) disable iff (1'b0)
        rst |=> out_latch_q == gxp_pkg::OUT_RST
        && invert_q == gxp_pkg::INV_RST && dir_q == gxp_pkg::DIR_RST
        && state_q == gxp_pkg::ST_IDLE)
        else $error("reset defaults wrong");

endmodule

/* bench/gxp_master.sv */
// Serial bus master model that drives the expander's link
`timescale 1ns/1ps
module gxp_master (
    // Serial link
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    // ****************************************************************
    // Bit timing
    // ****************************************************************
    // Quarter of the 125 ns link period; non-blocking updates keep an
    // edge that lands on a clock edge from racing the sampler
    localparam realtime QTR = 31.25;
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic s);
        #QTR o_sda_low <= ~b;
        #QTR o_scl <= 1'b1;
        #QTR s = i_sda;
        #QTR o_scl <= 1'b0;
    endtask
    task automatic start();
        #QTR o_sda_low <= 1'b0;
        #QTR o_scl <= 1'b1;
        #QTR o_sda_low <= 1'b1;
        #QTR o_scl <= 1'b0;
    endtask
    task automatic stop();
        #QTR o_sda_low <= 1'b1;
        #QTR o_scl <= 1'b1;
        #QTR o_sda_low <= 1'b0;
        #QTR;
    endtask
    // A 1 in ack_in releases the line: the nack that ends a read
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask
endmodule

/* bench/tb_i2c_gpio_expander_core.sv */
// Self-checking bench of the port expander core
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
module tb_i2c_gpio_expander_core;
    // ****************************************************************
    // Wiring
    // ****************************************************************
    logic       clk, rst, rpin_n, sel, scl, m_low, sda_oe, sda_o;
    logic       irq_o, irq_oe, ack;
    logic [7:0] ext, pout, poe, d, v, dirv, inv;
    int         num_errors, cmp_count, cyc;
    // Both lines have pull-ups
    wire        sda   = ~(m_low | (sda_oe & ~sda_o));
    wire        irq_n = ~(irq_oe & ~irq_o);
    wire  [7:0] port  = (poe & pout) | (~poe & ext);
    gxp_core dut_u (.i_clk(clk), .i_reset(rst), .i_reset_pin_n(rpin_n),
        .i_addr_sel(sel), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o),
        .o_sda_oe(sda_oe), .i_port(port), .o_port_out(pout),
        .o_port_oe(poe), .o_irq_n_out(irq_o), .o_irq_n_oe(irq_oe));
    gxp_master m_u (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [7:0] exp_in(logic [7:0] e, o, i, c);
        return ((~c & o) | (c & e)) ^ (i & c);
    endfunction
    task automatic wr(logic [7:0] r, logic [7:0] dat);
        logic [7:0] rx;
        m_u.start();
        m_u.xfer({6'h10, sel, 1'b0}, 1'b1, rx, ack);
        `CHK("write ack", 0, ack);
        m_u.xfer(r, 1'b1, rx, ack);
        m_u.xfer(dat, 1'b1, rx, ack);
        m_u.stop();
        tick(2);
    endtask
    task automatic rd(logic [7:0] r, logic cmd, output logic [7:0] dat);
        logic [7:0] rx;
        m_u.start();
        if (cmd) begin
            m_u.xfer({6'h10, sel, 1'b0}, 1'b1, rx, ack);
            m_u.xfer(r, 1'b1, rx, ack);
            m_u.start();
        end
        m_u.xfer({6'h10, sel, 1'b1}, 1'b1, rx, ack);
        `CHK("read ack", 0, ack);
        m_u.xfer(8'hff, 1'b1, dat, ack);
        `CHK("nack free", 1, sda);
        m_u.stop();
        tick(2);
    endtask
    task automatic chk_dflt();
        for (int r = 1; r < 4; r++) begin
            rd(8'(r), 1'b1, d);
            `CHK("default", (r == 2) ? 8'h00 : 8'hff, d);
        end
        `CHK("port oe", 8'h00, poe);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        void'($urandom(41801));
        {rst, rpin_n, ext} = {1'b1, 1'b1, 8'h00};
        sel = 1'($urandom);
        num_errors = 0;
        cmp_count = 0;
        tick(12);
        rst = 1'b0;
        tick(6);
        chk_dflt();
        repeat (4) begin
            {v, dirv, inv, ext} = $urandom;
            wr(1, v);
            wr(3, dirv);
            wr(2, inv);
            wr(0, ~v);
            `CHK("port out", v, pout);
            `CHK("port oe", ~dirv, poe);
            rd(1, 1'b1, d);
            `CHK("latch", v, d);
            rd(0, 1'b1, d);
            `CHK("input", exp_in(ext, v, inv, dirv), d);
        end
        rpin_n = 1'b0;
        tick(6);
        rpin_n = 1'b1;
        tick(6);
        chk_dflt();
        ext = 8'h3c;
        rd(0, 1'b1, d);
        `CHK("irq idle", 1, irq_n);
        ext ^= 8'h01;
        tick(8);
        `CHK("irq edge", 0, irq_n);
        // Traffic for another address must not touch the interrupt
        m_u.start();
        m_u.xfer(8'h44, 1'b1, v, ack);
        m_u.stop();
        tick(8);
        `CHK("other nack", 1, ack);
        `CHK("irq other", 0, irq_n);
        ext ^= 8'h01;
        tick(8);
        `CHK("irq return", 1, irq_n);
        ext ^= 8'h80;
        tick(8);
        `CHK("irq again", 0, irq_n);
        rd(0, 1'b0, d);
        `CHK("input kept", ext, d);
        `CHK("irq read", 1, irq_n);
        ext ^= 8'h80;
        tick(8);
        `CHK("irq third", 0, irq_n);
        wr(1, 8'h5a);
        `CHK("irq stop", 1, irq_n);
        wr(3, 8'h00);
        ext = ~ext;
        tick(8);
        `CHK("irq output", 1, irq_n);
        `CHK("out pins", 8'h5a, port);
        tally_and_finish();
    end
endmodule
